// >>> tb/tb_rfo.sv
// Self-checking testbench for the reference clock source, trim, status and tuning block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rfo_pkg::*;
   localparam logic [31:0] on_m = 32'h1 << RFO_ON_BIT;
   localparam logic [31:0] oe_m = 32'h1 << RFO_OE_BIT;
   localparam logic [31:0] slp_m = 32'h1 << RFO_RUN_SLEEP_BIT;
   localparam logic [31:0] dsw_m = 32'h1 << RFO_DSW_BIT;
   localparam logic [31:0] act_m = 32'h1 << RFO_ACT_BIT;
   localparam logic [31:0] sidl_m = 32'h1 << RFO_SIDL_BIT;
   logic clk, rst, psel, penable, pwrite, sleep, idle, pready, pslverr, refclk, refclk_oe, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, cur;
   logic [5:0] src, rdy, tune;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;

   rfo_refclk u_dut (
      .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .PRI_OSC_I(src[RFO_I_PRI]), .FAST_RC_OSC_I(src[RFO_I_FAST_RC]), .LOWP_RC_OSC_I(src[RFO_I_LOWP_RC]),
      .SEC_OSC_I(src[RFO_I_SEC]), .PLL_OUT_I(src[RFO_I_PLL]), .REF_CLK_IN_I(src[RFO_I_PIN]),
      .PLL_LOCK_I(rdy[0]), .LOWP_RC_READY_I(rdy[1]), .SEC_READY_I(rdy[2]), .PRI_READY_I(rdy[3]),
      .PLL_POST_READY_I(rdy[4]), .FAST_RC_READY_I(rdy[5]), .SLEEP_I(sleep), .IDLE_I(idle),
      .REFCLK_O(refclk), .REFCLK_OE_O(refclk_oe), .TUNE_O(tune)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // A hang anywhere ends the run here rather than in the simulator's own limit.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Only the bench timeout ends a wait that never sees ready.
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // The module is switched off before the select field changes, so the working divisor and trim copies load the new values.
   task automatic set_ctrl(input logic [31:0] v);
      apb(1'b1, RFO_OFS_CTRL, cur & ~on_m);
      apb(1'b1, RFO_OFS_CTRL, v & ~(on_m | dsw_m));
      apb(1'b1, RFO_OFS_CTRL, v);
      cur = v & ~dsw_m;
      apb(1'b0, RFO_OFS_CTRL, 32'h0);
      chk(rd, cur | (v[RFO_ON_BIT] ? act_m : 32'h0));
   endtask

   task automatic out_is(input logic exp);
      repeat (8) @(posedge clk);
      chk(32'(refclk), 32'(exp));
   endtask

   task automatic count_edges(output int n);
      logic last;
      n = 0;
      repeat (6) @(posedge clk);
      last = refclk;
      repeat (16) begin
         @(posedge clk);
         if (refclk !== last) n++;
         last = refclk;
      end
   endtask

   task automatic test_reset();
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rd, 32'h0);
         chk({31'h0, er}, 32'h0);
      end
      chk(32'(tune), 32'h0);
      $display("test reset done");
   endtask

   task automatic test_status();
      int pos [6] = '{7, 5, 4, 2, 1, 0};
      for (int i = 0; i < 6; i++) begin
         rdy <= 6'h1 << i;
         repeat (4) @(posedge clk);
         apb(1'b0, RFO_OFS_STAT, 32'h0);
         chk(rd, 32'h1 << pos[i]);
      end
      rdy <= 6'h3F;
      repeat (4) @(posedge clk);
      apb(1'b0, RFO_OFS_STAT, 32'h0);
      chk(rd, 32'h000000B7);
      apb(1'b1, RFO_OFS_STAT, 32'hFFFFFFFF);
      rdy <= 6'h00;
      repeat (4) @(posedge clk);
      apb(1'b0, RFO_OFS_STAT, 32'h0);
      chk(rd, 32'h0);
      $display("test status done");
   endtask

   task automatic test_regs();
      apb(1'b1, RFO_OFS_TRIM, 32'hFFFFFFFF);
      apb(1'b0, RFO_OFS_TRIM, 32'h0);
      chk(rd, 32'hFF800000);
      apb(1'b1, RFO_OFS_TUNE, 32'h0000003F);
      apb(1'b0, RFO_OFS_TUNE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, RFO_OFS_UNLK, RFO_KEY1);
      apb(1'b1, RFO_OFS_UNLK, RFO_KEY2);
      apb(1'b1, RFO_OFS_TUNE, 32'hFFFFFFEA);
      apb(1'b0, RFO_OFS_TUNE, 32'h0);
      chk(rd, 32'h0000002A);
      chk(32'(tune), 32'h0000002A);
      apb(1'b1, RFO_OFS_TUNE, 32'h00000015);
      apb(1'b0, RFO_OFS_TUNE, 32'h0);
      chk(rd, 32'h0000002A);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h20, 32'hFFFFFFFF);
      chk({31'h0, er}, 32'h1);
      $display("test registers done");
   endtask

   task automatic test_select();
      logic [3:0] code [6] = '{RFO_SEL_PRI, RFO_SEL_FAST_RC, RFO_SEL_LOWP_RC, RFO_SEL_SEC, RFO_SEL_PLL, RFO_SEL_PIN};
      int idx [6] = '{RFO_I_PRI, RFO_I_FAST_RC, RFO_I_LOWP_RC, RFO_I_SEC, RFO_I_PLL, RFO_I_PIN};
      int n;
      for (int i = 0; i < 6; i++) begin
         set_ctrl(on_m | oe_m | 32'(code[i]));
         src <= 6'h1 << idx[i];
         out_is(1'b1);
         src <= ~(6'h1 << idx[i]);
         out_is(1'b0);
      end
      chk(32'(refclk_oe), 32'h1);
      for (int c = 0; c < 2; c++) begin
         set_ctrl(on_m | oe_m | 32'(c));
         count_edges(n);
         chk(32'(n), 32'h10);
      end
      for (int c = 6; c < 16; c++) begin
         if (c != 7 && c != 9) begin
            set_ctrl(on_m | oe_m | 32'(c));
            src <= 6'h3F;
            out_is(1'b0);
            src <= 6'h00;
            out_is(1'b0);
         end
      end
      // Two rising edges of the half-rate toggle per half period give one output change every fourth cycle.
      apb(1'b1, RFO_OFS_TRIM, 32'h0);
      set_ctrl(on_m | oe_m | (32'h2 << RFO_DIV_LSB) | 32'(RFO_SEL_SYS1));
      count_edges(n);
      chk(32'(n), 32'h4);
      set_ctrl(on_m | oe_m | (32'h4 << RFO_DIV_LSB) | 32'(RFO_SEL_PRI));
      apb(1'b1, RFO_OFS_TRIM, 32'h80000000);
      apb(1'b1, RFO_OFS_CTRL, cur | dsw_m);
      repeat (4) @(posedge clk);
      apb(1'b0, RFO_OFS_CTRL, 32'h0);
      chk(rd & dsw_m, 32'h0);
      $display("test select done");
   endtask

   task automatic test_sleep();
      int n;
      set_ctrl(on_m | oe_m | 32'(RFO_SEL_PRI));
      src <= 6'h1 << RFO_I_PRI;
      // The bench's sleep stands for the non-retention form, so the pin may stay enabled.
      sleep <= 1'b1;
      out_is(1'b0);
      sleep <= 1'b0;
      idle <= 1'b1;
      out_is(1'b1);
      set_ctrl(on_m | oe_m | sidl_m | 32'(RFO_SEL_PRI));
      out_is(1'b0);
      idle <= 1'b0;
      out_is(1'b1);
      set_ctrl(on_m | oe_m | slp_m | 32'(RFO_SEL_PRI));
      sleep <= 1'b1;
      out_is(1'b1);
      sleep <= 1'b0;
      set_ctrl(on_m | oe_m | slp_m | 32'(RFO_SEL_SYS0));
      sleep <= 1'b1;
      count_edges(n);
      chk(32'(n), 32'h0);
      sleep <= 1'b0;
      $display("test sleep done");
   endtask

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      src = 6'h00;
      rdy = 6'h00;
      sleep = 1'b0;
      idle = 1'b0;
      cur = 32'h0;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_status();
      test_regs();
      test_select();
      test_sleep();
      // A second reset in mid-run must bring the CTRL, TRIM, STAT and TUNE registers back to their reset values.
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      give_verdict();
   end
endmodule // tb
`default_nettype wire

// >>> verilog/rfo_div_if.sv
// Interface between the register side and the output divider.
`timescale 1ns/1ps
`default_nettype none
interface rfo_div_if;
   import rfo_pkg::*;
   logic run;
   logic src_level;
   logic src_rise;
   logic [RFO_DIV_W-1:0] div;
   logic [RFO_TRIM_W-1:0] trim;
   logic out_clk;
   modport ctl (output run, output src_level, output src_rise, output div, output trim, input out_clk);
   modport gen (input run, input src_level, input src_rise, input div, input trim, output out_clk);
endinterface
`default_nettype wire

// >>> verilog/rfo_divider.sv
// Reference output divider with fractional trim accumulator.
`timescale 1ns/1ps
`default_nettype none
module rfo_divider
   import rfo_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   rfo_div_if.gen dif
);
   logic [RFO_DIV_W-1:0] cnt_reg;
   logic [RFO_TRIM_W-1:0] acc_reg;
   logic extra_reg;
   logic out_reg;
   logic [RFO_TRIM_W:0] acc_sum;
   logic [RFO_DIV_W:0] half_len;
   assign acc_sum = {1'b0, acc_reg} + {1'b0, dif.trim};
   assign half_len = {1'b0, dif.div} + {{RFO_DIV_W{1'b0}}, extra_reg};
   assign dif.out_clk = out_reg;

   // Each half period lasts div source edges; the trim carry stretches some by one.
   always_ff @(posedge clk_i) begin
      if (rst_i || !dif.run) begin
         cnt_reg <= '0;
         acc_reg <= '0;
         extra_reg <= 1'b0;
         out_reg <= 1'b0;
      end else if (dif.div == '0) begin
         out_reg <= dif.src_level;
         cnt_reg <= '0;
      end else if (dif.src_rise) begin
         if ({1'b0, cnt_reg} + 16'h0001 >= half_len) begin
            out_reg <= ~out_reg;
            cnt_reg <= '0;
            acc_reg <= acc_sum[RFO_TRIM_W-1:0];
            extra_reg <= acc_sum[RFO_TRIM_W];
         end else begin
            cnt_reg <= cnt_reg + 15'h1;
         end
      end
   end

   chk_stopped_low: assert property (@(posedge clk_i) disable iff (rst_i)
      !dif.run |=> !out_reg) else $error("Divider output not low while stopped.");
   chk_bypass_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      dif.run && dif.div == '0 |=> out_reg == $past(dif.src_level))
      else $error("Undivided output does not follow the source.");
   chk_no_toggle_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      dif.run && dif.div != '0 && !dif.src_rise && $past(dif.run) && $past(dif.div) != '0
      |=> $stable(out_reg)) else $error("Divider toggled without a source edge.");
endmodule // rfo_divider
`default_nettype wire

// >>> verilog/rfo_pkg.sv
// Constants and types shared by the reference clock source, trim and status block.
package rfo_pkg;
   localparam logic [7:0] RFO_OFS_CTRL = 8'h00;
   localparam logic [7:0] RFO_OFS_TRIM = 8'h04;
   localparam logic [7:0] RFO_OFS_STAT = 8'h08;
   localparam logic [7:0] RFO_OFS_TUNE = 8'h0C;
   localparam logic [7:0] RFO_OFS_UNLK = 8'h10;
   // Unlock keys are arbitrary values.
   localparam logic [31:0] RFO_KEY1 = 32'hAA55AA55;
   localparam logic [31:0] RFO_KEY2 = 32'h55AA55AA;
   localparam int RFO_DIV_W = 15;
   localparam int RFO_TRIM_W = 9;
   localparam int RFO_TUNE_W = 6;
   localparam int RFO_DIV_LSB = 16;
   localparam int RFO_ON_BIT = 15;
   localparam int RFO_SIDL_BIT = 13;
   localparam int RFO_OE_BIT = 12;
   localparam int RFO_RUN_SLEEP_BIT = 11;
   localparam int RFO_DSW_BIT = 9;
   localparam int RFO_ACT_BIT = 8;
   localparam int RFO_TRIM_LSB = 23;
   localparam int RFO_NSRC = 6;
   localparam int RFO_NRDY = 6;
   localparam logic [3:0] RFO_SEL_SYS0 = 4'h0;
   localparam logic [3:0] RFO_SEL_SYS1 = 4'h1;
   localparam logic [3:0] RFO_SEL_PRI = 4'h2;
   localparam logic [3:0] RFO_SEL_FAST_RC = 4'h3;
   localparam logic [3:0] RFO_SEL_LOWP_RC = 4'h4;
   localparam logic [3:0] RFO_SEL_SEC = 4'h5;
   localparam logic [3:0] RFO_SEL_PLL = 4'h7;
   localparam logic [3:0] RFO_SEL_PIN = 4'h9;
   // Index of each source in the synchronised pin vector.
   localparam int RFO_I_PRI = 0;
   localparam int RFO_I_FAST_RC = 1;
   localparam int RFO_I_LOWP_RC = 2;
   localparam int RFO_I_SEC = 3;
   localparam int RFO_I_PLL = 4;
   localparam int RFO_I_PIN = 5;
   typedef enum logic [1:0] {RFO_LOCKED, RFO_KEY1_SEEN, RFO_OPEN} rfo_unlock_t;
endpackage

// >>> verilog/rfo_refclk.sv
// Reference clock source select, trim, oscillator status and fast RC tuning over APB.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rfo_refclk
   import rfo_pkg::*;
(
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic PRI_OSC_I,
   input wire logic FAST_RC_OSC_I,
   input wire logic LOWP_RC_OSC_I,
   input wire logic SEC_OSC_I,
   input wire logic PLL_OUT_I,
   input wire logic REF_CLK_IN_I,
   input wire logic PLL_LOCK_I,
   input wire logic LOWP_RC_READY_I,
   input wire logic SEC_READY_I,
   input wire logic PRI_READY_I,
   input wire logic PLL_POST_READY_I,
   input wire logic FAST_RC_READY_I,
   input wire logic SLEEP_I,
   input wire logic IDLE_I,
   output logic REFCLK_O,
   output logic REFCLK_OE_O,
   output logic [RFO_TUNE_W-1:0] TUNE_O
);
   logic [RFO_NSRC-1:0] src_s;
   logic [RFO_NSRC-1:0] src_d_reg;
   logic [RFO_NRDY-1:0] rdy_s;
   logic sys_tgl_reg;
   logic [RFO_DIV_W-1:0] div_reg;
   logic [RFO_DIV_W-1:0] div_act_reg;
   logic [RFO_TRIM_W-1:0] trim_reg;
   logic [RFO_TRIM_W-1:0] trim_act_reg;
   logic [3:0] sel_reg;
   logic on_reg;
   logic sidl_reg;
   logic oe_reg;
   logic ref_run_in_sleep_reg;
   logic dsw_reg;
   logic active_reg;
   logic [RFO_TUNE_W-1:0] tune_reg;
   rfo_unlock_t unlock_reg;
   logic wr_en;
   logic sel_level;
   logic sel_rise;
   logic sleep_stop;
   logic run;
   logic mapped;
   logic [31:0] ctrl_val;
   logic [31:0] stat_val;
   logic [31:0] rd_next;
   rfo_div_if dif ();

   rfo_sync #(.WIDTH(RFO_NSRC)) u_src_sync (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .d_i({REF_CLK_IN_I, PLL_OUT_I, SEC_OSC_I, LOWP_RC_OSC_I, FAST_RC_OSC_I, PRI_OSC_I}),
      .q_o(src_s)
   );
   // Ready flags in status bit order 7,5,4,2,1,0.
   rfo_sync #(.WIDTH(RFO_NRDY)) u_rdy_sync (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .d_i({PLL_LOCK_I, LOWP_RC_READY_I, SEC_READY_I, PRI_READY_I, PLL_POST_READY_I, FAST_RC_READY_I}),
      .q_o(rdy_s)
   );

   // The system clock cannot be sampled by itself, so a half-rate toggle stands in for it.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         sys_tgl_reg <= 1'b0;
         src_d_reg <= '0;
      end else begin
         sys_tgl_reg <= ~sys_tgl_reg;
         src_d_reg <= src_s;
      end
   end

   always_comb begin
      sel_level = 1'b0;
      sel_rise = 1'b0;
      case (sel_reg)
         RFO_SEL_SYS0, RFO_SEL_SYS1: begin
            sel_level = sys_tgl_reg;
            sel_rise = ~sys_tgl_reg;
         end
         RFO_SEL_PRI: begin
            sel_level = src_s[RFO_I_PRI];
            sel_rise = src_s[RFO_I_PRI] & ~src_d_reg[RFO_I_PRI];
         end
         RFO_SEL_FAST_RC: begin
            sel_level = src_s[RFO_I_FAST_RC];
            sel_rise = src_s[RFO_I_FAST_RC] & ~src_d_reg[RFO_I_FAST_RC];
         end
         RFO_SEL_LOWP_RC: begin
            sel_level = src_s[RFO_I_LOWP_RC];
            sel_rise = src_s[RFO_I_LOWP_RC] & ~src_d_reg[RFO_I_LOWP_RC];
         end
         RFO_SEL_SEC: begin
            sel_level = src_s[RFO_I_SEC];
            sel_rise = src_s[RFO_I_SEC] & ~src_d_reg[RFO_I_SEC];
         end
         RFO_SEL_PLL: begin
            sel_level = src_s[RFO_I_PLL];
            sel_rise = src_s[RFO_I_PLL] & ~src_d_reg[RFO_I_PLL];
         end
         RFO_SEL_PIN: begin
            sel_level = src_s[RFO_I_PIN];
            sel_rise = src_s[RFO_I_PIN] & ~src_d_reg[RFO_I_PIN];
         end
         default: begin
            sel_level = 1'b0;
            sel_rise = 1'b0;
         end
      endcase
   end

   // With select code 0 the system clock itself stops in sleep, so run-in-sleep cannot help.
   assign sleep_stop = SLEEP_I & (~ref_run_in_sleep_reg | (sel_reg == RFO_SEL_SYS0));
   assign run = on_reg & active_reg & ~sleep_stop & ~(IDLE_I & sidl_reg);
   assign dif.run = run;
   assign dif.src_level = sel_level;
   assign dif.src_rise = sel_rise;
   assign dif.div = div_act_reg;
   assign dif.trim = trim_act_reg;

   rfo_divider u_div (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .dif(dif)
   );

   // A write takes effect at the edge that completes the access phase.
   assign wr_en = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         div_reg <= '0;
         sel_reg <= '0;
         on_reg <= 1'b0;
         sidl_reg <= 1'b0;
         oe_reg <= 1'b0;
         ref_run_in_sleep_reg <= 1'b0;
      end else if (wr_en && PADDR_I == RFO_OFS_CTRL) begin
         div_reg <= PWDATA_I[RFO_DIV_LSB +: RFO_DIV_W];
         sel_reg <= PWDATA_I[3:0];
         on_reg <= PWDATA_I[RFO_ON_BIT];
         sidl_reg <= PWDATA_I[RFO_SIDL_BIT];
         oe_reg <= PWDATA_I[RFO_OE_BIT];
         ref_run_in_sleep_reg <= PWDATA_I[RFO_RUN_SLEEP_BIT];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         trim_reg <= '0;
      end else if (wr_en && PADDR_I == RFO_OFS_TRIM) begin
         trim_reg <= PWDATA_I[RFO_TRIM_LSB +: RFO_TRIM_W];
      end
   end

   // A software set wins over the hardware clear in the same cycle.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         dsw_reg <= 1'b0;
      end else if (wr_en && PADDR_I == RFO_OFS_CTRL && PWDATA_I[RFO_DSW_BIT]) begin
         dsw_reg <= 1'b1;
      end else if (dsw_reg) begin
         dsw_reg <= 1'b0;
      end
   end

   // Disabled, the working copies track software; enabled, they move only on a switch request.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         div_act_reg <= '0;
         trim_act_reg <= '0;
      end else if (!on_reg || dsw_reg) begin
         div_act_reg <= div_reg;
         trim_act_reg <= trim_reg;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         active_reg <= 1'b0;
      end else begin
         active_reg <= on_reg;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         unlock_reg <= RFO_LOCKED;
         tune_reg <= '0;
      end else if (wr_en && PADDR_I == RFO_OFS_UNLK) begin
         if (PWDATA_I == RFO_KEY1) begin
            unlock_reg <= RFO_KEY1_SEEN;
         end else if (PWDATA_I == RFO_KEY2 && unlock_reg == RFO_KEY1_SEEN) begin
            unlock_reg <= RFO_OPEN;
         end else begin
            unlock_reg <= RFO_LOCKED;
         end
      end else if (wr_en && PADDR_I == RFO_OFS_TUNE) begin
         unlock_reg <= RFO_LOCKED;
         if (unlock_reg == RFO_OPEN) begin
            tune_reg <= PWDATA_I[RFO_TUNE_W-1:0];
         end
      end
   end

   always_comb begin
      ctrl_val = '0;
      ctrl_val[RFO_DIV_LSB +: RFO_DIV_W] = div_reg;
      ctrl_val[RFO_ON_BIT] = on_reg;
      ctrl_val[RFO_SIDL_BIT] = sidl_reg;
      ctrl_val[RFO_OE_BIT] = oe_reg;
      ctrl_val[RFO_RUN_SLEEP_BIT] = ref_run_in_sleep_reg;
      ctrl_val[RFO_DSW_BIT] = dsw_reg;
      ctrl_val[RFO_ACT_BIT] = active_reg;
      ctrl_val[3:0] = sel_reg;
   end

   assign stat_val = {24'h000000, rdy_s[5], 1'b0, rdy_s[4:3], 1'b0, rdy_s[2:0]};

   always_comb begin
      mapped = 1'b1;
      rd_next = '0;
      if (PADDR_I == RFO_OFS_CTRL) begin
         rd_next = ctrl_val;
      end else if (PADDR_I == RFO_OFS_TRIM) begin
         rd_next = {trim_reg, 23'h0};
      end else if (PADDR_I == RFO_OFS_STAT) begin
         rd_next = stat_val;
      end else if (PADDR_I == RFO_OFS_TUNE) begin
         rd_next = {26'h0, tune_reg};
      end else if (PADDR_I == RFO_OFS_UNLK) begin
         rd_next = {31'h0, unlock_reg == RFO_OPEN};
      end else begin
         mapped = 1'b0;
      end
   end

   // Ready is raised in the first access cycle, so every transfer takes exactly two cycles.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= '0;
      end else begin
         PREADY_O <= PSEL_I & ~PENABLE_I;
         PSLVERR_O <= PSEL_I & ~PENABLE_I & ~mapped;
         PRDATA_O <= (PSEL_I && !PENABLE_I && !PWRITE_I) ? rd_next : 32'h00000000;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         REFCLK_O <= 1'b0;
         REFCLK_OE_O <= 1'b0;
         TUNE_O <= '0;
      end else begin
         REFCLK_O <= oe_reg & dif.out_clk;
         REFCLK_OE_O <= oe_reg & on_reg;
         TUNE_O <= tune_reg;
      end
   end

   chk_sys_source: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      sel_reg == RFO_SEL_SYS0 || sel_reg == RFO_SEL_SYS1 |-> sel_rise == ~sys_tgl_reg)
      else $error("System clock not taken for low select codes.");
   chk_fast_rc_source: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      sel_reg == RFO_SEL_FAST_RC |-> sel_level == src_s[RFO_I_FAST_RC])
      else $error("Fast RC source not selected.");
   chk_pin_source: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      sel_reg == RFO_SEL_PIN |-> sel_level == src_s[RFO_I_PIN])
      else $error("Input pin source not selected.");
   chk_reserved_static: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      sel_reg == 4'h6 || sel_reg == 4'h8 || sel_reg > RFO_SEL_PIN |-> !sel_rise && !sel_level)
      else $error("Reserved select code produced a clock.");
   chk_sleep_sys: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      SLEEP_I && sel_reg == RFO_SEL_SYS0 |-> !run)
      else $error("System clock source ran in sleep.");
   chk_trim_held: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      on_reg && $past(on_reg) && !$past(dsw_reg) |-> $stable(trim_act_reg))
      else $error("Trim applied without a switch request.");
   chk_switch_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      dsw_reg && !(wr_en && PADDR_I == RFO_OFS_CTRL && PWDATA_I[RFO_DSW_BIT])
      |=> !dsw_reg && trim_act_reg == $past(trim_reg))
      else $error("Switch request not completed in one cycle.");
   chk_active_follow: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      $rose(on_reg) |-> !active_reg ##1 active_reg)
      else $error("Active does not follow enable.");
   chk_tune_locked: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      unlock_reg != RFO_OPEN |=> $stable(tune_reg))
      else $error("Tuning changed without unlock.");
   chk_lock_status: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == RFO_OFS_STAT
      |=> PRDATA_O[7] == $past(rdy_s[5]) && PRDATA_O[31:8] == 24'h000000)
      else $error("Status read does not match lock flag.");

   cov_trim_switch: cover property (@(posedge CLK_I) on_reg && wr_en && PADDR_I == RFO_OFS_CTRL && PWDATA_I[RFO_DSW_BIT]);
   cov_tune_write: cover property (@(posedge CLK_I) unlock_reg == RFO_OPEN && wr_en && PADDR_I == RFO_OFS_TUNE);
   cov_sleep_run: cover property (@(posedge CLK_I) SLEEP_I && run);
   cov_out_toggle: cover property (@(posedge CLK_I) REFCLK_OE_O && $rose(REFCLK_O));
endmodule // rfo_refclk
`default_nettype wire

// >>> verilog/rfo_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module rfo_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule // rfo_sync
`default_nettype wire
